// ===== rtl/wdtlfs_top.sv
`timescale 1ns/100ps
module wdtlfs_top
  import wdtlfs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        osc_32k,
  input  wire logic        debug_halt,
  input  wire logic        periph_powerdown,
  input  wire logic        capture_enable,
  input  wire logic        capture_event,
  output logic             wdt_reset_req,
  output logic             wdt_irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [31:0]  aw_addr_ff;
  logic         aw_held_ff;
  logic [31:0]  w_data_ff;
  logic [3:0]   w_strb_ff;
  logic         w_held_ff;
  logic         bvalid_ff;
  logic [1:0]   bresp_ff;
  logic         rvalid_ff;
  logic [1:0]   rresp_ff;
  logic [31:0]  rdata_ff;
  logic [15:0]  reload_ff;
  logic [15:0]  count_ff;
  logic [15:0]  control_ff;
  logic [15:0]  capture_ff;
  wdtlfs_mode_e mode_ff;
  logic         osc_s1_ff;
  logic         osc_s2_ff;
  logic         osc_prev_ff;
  logic         dbg_s1_ff;
  logic         dbg_s2_ff;
  logic [7:0]   presc_ff;
  logic         reset_req_ff;
  logic         irq_ff;
  logic [7:0]   lfsr_state;

  // register-file byte-lane merge
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    merge16 = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // bus slave: write path
  // ----------------------------------------------------------------
  logic        wr_exec;
  logic        wr_reload;
  logic        wr_control;
  logic        wr_service;
  logic        wr_mapped;
  logic        locked;
  logic [15:0] nxt_reload;
  logic [15:0] nxt_control;

  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready  = !w_held_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;

  // address and data may come in either order; act once both are held
  assign wr_exec    = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_reload  = wr_exec && (aw_addr_ff == ADDR_RELOAD);
  assign wr_control = wr_exec && (aw_addr_ff == ADDR_CONTROL);
  assign wr_service = wr_exec && (aw_addr_ff == ADDR_SERVICE) && w_strb_ff[0];
  assign wr_mapped  = (aw_addr_ff == ADDR_RELOAD) || (aw_addr_ff == ADDR_CONTROL) ||
                      (aw_addr_ff == ADDR_SERVICE);
  assign locked     = (mode_ff == WDTLFS_WATCHDOG);
  assign nxt_reload = (wr_reload && !locked) ? merge16(reload_ff, w_data_ff, w_strb_ff)
                                             : reload_ff;
  assign nxt_control = (wr_control && !locked)
                     ? (merge16(control_ff, w_data_ff, w_strb_ff) & CTL_WMASK)
                     : control_ff;

  // channel holding registers and the write answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      aw_addr_ff <= 32'h0000_0000;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_exec) begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus slave: read path
  // ----------------------------------------------------------------
  logic        rd_take;
  logic        rd_mapped;
  logic [15:0] rd_value;

  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign rd_take       = s_axi_arvalid && s_axi_arready;
  // service register is write only and the sequence state has no read path
  assign rd_value  = (s_axi_araddr == ADDR_RELOAD)  ? reload_ff  :
                     (s_axi_araddr == ADDR_COUNT)   ? count_ff   :
                     (s_axi_araddr == ADDR_CONTROL) ? control_ff :
                     (s_axi_araddr == ADDR_CAPTURE) ? capture_ff : 16'h0000;
  assign rd_mapped = (s_axi_araddr == ADDR_RELOAD) || (s_axi_araddr == ADDR_COUNT) ||
                     (s_axi_araddr == ADDR_CONTROL) || (s_axi_araddr == ADDR_CAPTURE);

  // one read in flight; answer on the edge after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= RESP_OKAY;
      rdata_ff  <= 32'h0000_0000;
    end else if (rd_take) begin
      rvalid_ff <= 1'b1;
      rresp_ff  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      rdata_ff  <= {16'h0000, rd_value};
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and oscillator edge
  // ----------------------------------------------------------------
  logic osc_edge;

  // oscillator and debug come from outside this clock; two flops first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_s1_ff   <= 1'b0;
      osc_s2_ff   <= 1'b0;
      osc_prev_ff <= 1'b0;
      dbg_s1_ff   <= 1'b0;
      dbg_s2_ff   <= 1'b0;
    end else begin
      osc_s1_ff   <= osc_32k;
      osc_s2_ff   <= osc_s1_ff;
      osc_prev_ff <= osc_s2_ff;
      dbg_s1_ff   <= debug_halt;
      dbg_s2_ff   <= dbg_s1_ff;
    end
  end

  assign osc_edge = osc_s2_ff && !osc_prev_ff;

  // ----------------------------------------------------------------
  // prescaler and run gating
  // ----------------------------------------------------------------
  logic [1:0] presc_code;
  logic [7:0] presc_last;
  logic       run;
  logic       tick;
  logic       presc_hit;

  assign presc_code = control_ff[CTL_PRESC_HI:CTL_PRESC_LO];
  // reserved code 11 falls back to divide by one
  assign presc_last = (presc_code == PRESC_DIV16)  ? DIV16_LAST  :
                      (presc_code == PRESC_DIV256) ? DIV256_LAST : DIV1_LAST;
  assign presc_hit  = (presc_ff >= presc_last);
  // watchdog mode runs even with the enable clear, so a lock cannot freeze it
  assign run = (control_ff[CTL_EN] || locked) && !dbg_s2_ff &&
               !(control_ff[CTL_PDOFF] && periph_powerdown);
  assign tick = osc_edge && run && presc_hit;

  // divider counts oscillator edges only while running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_ff <= 8'h00;
    end else if (osc_edge && run) begin
      presc_ff <= presc_hit ? 8'h00 : presc_ff + 8'h01;
    end
  end

  // ----------------------------------------------------------------
  // counter, service check and events
  // ----------------------------------------------------------------
  logic        count_up;
  logic        at_end;
  logic        timeout_ev;
  logic        secure;
  logic        svc_bad;
  logic        svc_good;
  logic        do_reload;
  logic [15:0] nxt_count;
  logic        nxt_reset_req;
  logic        irq_set;

  assign count_up   = control_ff[CTL_UP] && !locked;
  assign at_end     = count_up ? (count_ff == COUNT_FULL) : (count_ff == COUNT_ZERO);
  assign timeout_ev = tick && at_end;
  assign secure     = locked && control_ff[CTL_SECURE];
  // a zero expected value can never be served
  assign svc_bad  = wr_service && secure &&
                    ((w_data_ff[7:0] != lfsr_state) || (lfsr_state == LFSR_ZERO));
  assign svc_good = wr_service && !svc_bad;
  assign do_reload = svc_good ||
                     (timeout_ev && (locked || control_ff[CTL_PERIODIC]));
  // free-running wraps through the natural 16-bit roll-over
  assign nxt_count = do_reload ? reload_ff :
                     tick      ? (count_up ? count_ff + 16'h0001 : count_ff - 16'h0001) :
                                 count_ff;
  assign nxt_reset_req = locked && ((timeout_ev && !control_ff[CTL_INTERRUPT_ENABLE_MASK]) || svc_bad);
  assign irq_set       = timeout_ev && (!locked || control_ff[CTL_INTERRUPT_ENABLE_MASK]);

  // configuration and count; only aresetn (power-on) touches them
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reload_ff  <= RELOAD_RST;
      control_ff <= CONTROL_RST;
      count_ff   <= COUNT_RST;
      mode_ff    <= WDTLFS_NORMAL;
    end else begin
      reload_ff  <= nxt_reload;
      control_ff <= nxt_control;
      count_ff   <= nxt_count;
      if (nxt_control[CTL_WDMODE]) begin
        mode_ff <= WDTLFS_WATCHDOG;
      end
    end
  end

  // reset request pulse and sticky interrupt; a new event beats the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      reset_req_ff <= 1'b0;
      irq_ff       <= 1'b0;
      capture_ff   <= CAPTURE_RST;
    end else begin
      reset_req_ff <= nxt_reset_req;
      irq_ff       <= irq_set || (irq_ff && !wr_service);
      if (capture_event && capture_enable && !locked) begin
        capture_ff <= count_ff;
      end
    end
  end

  assign wdt_reset_req = reset_req_ff;
  assign wdt_irq       = irq_ff;

  // ----------------------------------------------------------------
  // expected service sequence
  // ----------------------------------------------------------------
  wdtlfs_lfsr u_lfsr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .load     (wr_service && !locked),
    .seed     (w_data_ff[7:0]),
    .advance  (svc_good && secure),
    .state_ff (lfsr_state)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_one_pulse;
    wdt_reset_req ##1 !wdt_reset_req;
  endsequence

  property p_svc_reload;
    svc_good |=> (count_ff == $past(reload_ff));
  endproperty
  a_svc_reload: assert property (p_svc_reload) else $error("service write did not reload");

  property p_lock;
    (locked && wr_exec) |=> $stable(control_ff) && $stable(reload_ff);
  endproperty
  a_lock: assert property (p_lock) else $error("locked register changed");

  property p_timeout_reset;
    (locked && timeout_ev && !control_ff[CTL_INTERRUPT_ENABLE_MASK]) |=> s_one_pulse;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset) else $error("no reset pulse at zero");

  property p_timeout_irq;
    (locked && timeout_ev && control_ff[CTL_INTERRUPT_ENABLE_MASK]) |=> (wdt_irq && !wdt_reset_req);
  endproperty
  a_timeout_irq: assert property (p_timeout_irq) else $error("irq option not honoured");

  property p_bad_service;
    svc_bad |=> s_one_pulse;
  endproperty
  a_bad_service: assert property (p_bad_service) else $error("bad service gave no reset");

  property p_advance;
    (svc_good && secure) |=> (lfsr_state == wdtlfs_lfsr_next($past(lfsr_state)));
  endproperty
  a_advance: assert property (p_advance) else $error("sequence did not advance");

  property p_debug_halt;
    (dbg_s2_ff && !wr_service) |=> $stable(count_ff);
  endproperty
  a_debug_halt: assert property (p_debug_halt) else $error("count moved during debug");

  property p_powerdown;
    (control_ff[CTL_PDOFF] && periph_powerdown && !wr_service) |=> $stable(count_ff);
  endproperty
  a_powerdown: assert property (p_powerdown) else $error("count moved in power-down");

  property p_count_up;
    (tick && count_up && !do_reload) |=> (count_ff == $past(count_ff) + 16'h0001);
  endproperty
  a_count_up: assert property (p_count_up) else $error("up count step wrong");

  property p_zero_seed;
    (secure && wr_service && lfsr_state == LFSR_ZERO) |=> wdt_reset_req;
  endproperty
  a_zero_seed: assert property (p_zero_seed) else $error("zero seed did not reset");

endmodule

// ===== rtl/wdtlfs_pkg.sv
package wdtlfs_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_RELOAD  = 32'hffff_0360;
  localparam logic [31:0] ADDR_COUNT   = 32'hffff_0364;
  localparam logic [31:0] ADDR_CONTROL = 32'hffff_0368;
  localparam logic [31:0] ADDR_SERVICE = 32'hffff_036c;
  localparam logic [31:0] ADDR_CAPTURE = 32'hffff_0370;

  // reset values
  localparam logic [15:0] RELOAD_RST   = 16'h3bf8;
  localparam logic [15:0] COUNT_RST    = 16'h3bf8;
  localparam logic [15:0] CONTROL_RST  = 16'h0000;
  localparam logic [15:0] CAPTURE_RST  = 16'h0000;
  localparam logic [7:0]  SEED_RST     = 8'h00;

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int CTL_UP       = 8;
  localparam int CTL_EN       = 7;
  localparam int CTL_PERIODIC = 6;
  localparam int CTL_WDMODE   = 5;
  localparam int CTL_SECURE   = 4;
  localparam int CTL_PRESC_HI = 3;
  localparam int CTL_PRESC_LO = 2;
  localparam int CTL_INTERRUPT_ENABLE_MASK    = 1;
  localparam int CTL_PDOFF    = 0;
  localparam logic [15:0] CTL_WMASK = 16'h01ff;  // reserved [15:9] read zero

  // prescaler codes and last count of each divider
  localparam logic [1:0] PRESC_DIV1   = 2'h0;
  localparam logic [1:0] PRESC_DIV16  = 2'h1;
  localparam logic [1:0] PRESC_DIV256 = 2'h2;
  localparam logic [7:0] DIV1_LAST    = 8'h00;
  localparam logic [7:0] DIV16_LAST   = 8'h0f;
  localparam logic [7:0] DIV256_LAST  = 8'hff;

  // count limits
  localparam logic [15:0] COUNT_ZERO = 16'h0000;
  localparam logic [15:0] COUNT_FULL = 16'hffff;

  // secure-clear sequence feedback (x^6, x^5, x, 1)
  localparam logic [7:0] LFSR_TAPS = 8'h63;
  localparam logic [7:0] LFSR_ZERO = 8'h00;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    WDTLFS_NORMAL   = 1'b0,
    WDTLFS_WATCHDOG = 1'b1
  } wdtlfs_mode_e;

  // next state of the expected-service sequence
  function automatic logic [7:0] wdtlfs_lfsr_next(input logic [7:0] cur);
    wdtlfs_lfsr_next = cur[7] ? ({cur[6:0], 1'b0} ^ LFSR_TAPS) : {cur[6:0], 1'b0};
  endfunction

endpackage

// ===== rtl/wdtlfs_lfsr.sv
`timescale 1ns/100ps
module wdtlfs_lfsr
  import wdtlfs_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       load,
  input  wire logic [7:0] seed,
  input  wire logic       advance,
  output logic      [7:0] state_ff
);

  // ----------------------------------------------------------------
  // expected service value
  // ----------------------------------------------------------------
  logic [7:0] nxt_state;

  // load wins over advance; both never meet since they need opposite modes
  assign nxt_state = load ? seed : (advance ? wdtlfs_lfsr_next(state_ff) : state_ff);

  // state is internal only, software must track it on its own
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= SEED_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

endmodule

// ===== verification/wdtlfs_sw_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// software-side register master
// ----------------------------------------------------------------
module wdtlfs_sw_model (
  input  wire logic        aclk,
  output logic      [31:0] s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic      [31:0] s_axi_wdata,
  output logic      [3:0]  s_axi_wstrb,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic      [31:0] s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready,
  output logic             hung
);
  // idle bus; hung flags a slave that never answers
  initial begin
    s_axi_awaddr  = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata   = '0;
    s_axi_wstrb   = 4'h0;
    s_axi_wvalid  = 1'b0;
    s_axi_bready  = 1'b0;
    s_axi_araddr  = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready  = 1'b0;
    hung          = 1'b0;
  end

  // one write; payload is inverted once taken so a stale value never looks valid
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    bit aw_d;
    bit w_d;
    aw_d = 1'b0;
    w_d  = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hf;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (aw_d && w_d && s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      if (!aw_d && s_axi_awready === 1'b1) begin
        aw_d = 1'b1;
        s_axi_awvalid <= 1'b0;
        s_axi_awaddr  <= ~a;
      end
      if (!w_d && s_axi_wready === 1'b1) begin
        w_d = 1'b1;
        s_axi_wvalid <= 1'b0;
        s_axi_wdata  <= ~d;
      end
    end
    if (n == 200) hung <= 1'b1;
  endtask

  // one read; data and response taken at the edge that sees rvalid
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    bit ar_d;
    ar_d = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (ar_d && s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
      if (!ar_d && s_axi_arready === 1'b1) begin
        ar_d = 1'b1;
        s_axi_arvalid <= 1'b0;
        s_axi_araddr  <= ~a;
      end
    end
    if (n == 200) hung <= 1'b1;
  endtask
endmodule

// ===== verification/tb_watchdog_timer_lfsr_clear.sv
`timescale 1ns/100ps
module tb_watchdog_timer_lfsr_clear;
  import wdtlfs_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        aclk, aresetn, osc_32k, debug_halt, periph_powerdown;
  logic        capture_enable, capture_event, wdt_reset_req, wdt_irq, hung;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  int          error_cnt = 0;
  int          checks = 0;
  int          rst_seen = 0;
  int          i;
  logic [31:0] v;
  logic [31:0] a;
  logic [1:0]  r;
  logic [15:0] d;
  logic [7:0]  seq [3] = '{8'haa, 8'h37, 8'h6e};

  wdtlfs_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .osc_32k, .debug_halt, .periph_powerdown,
    .capture_enable, .capture_event, .wdt_reset_req, .wdt_irq);
  wdtlfs_sw_model sw_u (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .hung);

  // ----------------------------------------------------------------
  // clocks and monitors
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // oscillator sped up to a tick every 16 aclk so timeouts stay short
  initial begin
    osc_32k = 1'b0;
    forever #200 osc_32k = ~osc_32k;
  end
  always @(posedge aclk) if (wdt_reset_req === 1'b1) rst_seen++;
  always @(posedge hung) begin
    error_cnt++;
    wrap_up();
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdc(input logic [31:0] ad, input logic [31:0] exp, input logic [1:0] er);
    sw_u.rd(ad, v, r);
    chk({30'h0, r}, {30'h0, er});
    chk(v, exp);
  endtask
  task automatic wrc(input logic [31:0] ad, input logic [31:0] dt, input logic [1:0] er);
    sw_u.wr(ad, dt, r);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // bounded waits: running out is a failure and ends the run
  task automatic wait_irq(input int lim);
    int n;
    for (n = 0; n < lim && wdt_irq !== 1'b1; n++) @(posedge aclk);
    if (n == lim) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  task automatic wait_rst(input int tgt, input int lim);
    int n;
    for (n = 0; n < lim && rst_seen < tgt; n++) @(posedge aclk);
    if (n == lim) begin
      error_cnt++;
      wrap_up();
    end
  endtask
  // change of the count over a 64-cycle window
  task automatic drift(output logic [15:0] dl);
    logic [15:0] c0;
    sw_u.rd(ADDR_COUNT, v, r);
    c0 = v[15:0];
    wait_cyc(64);
    sw_u.rd(ADDR_COUNT, v, r);
    dl = v[15:0] - c0;
  endtask
  task automatic por;
    aresetn <= 1'b0;
    wait_cyc(4);
    aresetn <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    debug_halt = 1'b0;
    periph_powerdown = 1'b0;
    capture_enable = 1'b0;
    capture_event = 1'b0;
    por();
    rdc(ADDR_RELOAD, 32'h0000_3bf8, RESP_OKAY);
    rdc(ADDR_COUNT, 32'h0000_3bf8, RESP_OKAY);
    rdc(ADDR_CONTROL, 32'h0000_0000, RESP_OKAY);
    rdc(ADDR_SERVICE, 32'h0000_0000, RESP_SLVERR);
    rdc(32'hffff_0378, 32'h0000_0000, RESP_SLVERR);
    wrc(ADDR_COUNT, 32'h0000_0001, RESP_SLVERR);
    // periodic then free-running down count, irq at the end
    wrc(ADDR_RELOAD, 32'h0000_0004, RESP_OKAY);
    wrc(ADDR_SERVICE, 32'h0000_0000, RESP_OKAY);
    wrc(ADDR_CONTROL, 32'h0000_00c0, RESP_OKAY);
    wait_irq(400);
    sw_u.rd(ADDR_COUNT, v, r);
    chk(32'(v <= 32'h0000_0004), 32'h0000_0001);
    wrc(ADDR_SERVICE, 32'h0000_0000, RESP_OKAY);
    wait_cyc(2);
    chk(32'(wdt_irq), 32'h0000_0000);
    wrc(ADDR_CONTROL, 32'h0000_0080, RESP_OKAY);
    wrc(ADDR_SERVICE, 32'h0000_0000, RESP_OKAY);
    wait_irq(400);
    sw_u.rd(ADDR_COUNT, v, r);
    chk(32'(v[15:8] == 8'hff), 32'h0000_0001);
    // disabled counter holds; capture copies it
    wrc(ADDR_CONTROL, 32'h0000_0000, RESP_OKAY);
    drift(d);
    chk({16'h0, d}, 32'h0000_0000);
    sw_u.rd(ADDR_COUNT, v, r);
    a = v;
    capture_enable <= 1'b1;
    @(posedge aclk);
    capture_event <= 1'b1;
    @(posedge aclk);
    capture_event <= 1'b0;
    rdc(ADDR_CAPTURE, a, RESP_OKAY);
    // direction, debug halt and power-down stop
    wrc(ADDR_RELOAD, 32'h0000_1000, RESP_OKAY);
    wrc(ADDR_SERVICE, 32'h0000_0000, RESP_OKAY);
    wrc(ADDR_CONTROL, 32'h0000_0080, RESP_OKAY);
    drift(d);
    chk(32'(d inside {[16'hfffa:16'hfffd]}), 32'h0000_0001);
    debug_halt <= 1'b1;
    wait_cyc(4);
    drift(d);
    chk({16'h0, d}, 32'h0000_0000);
    debug_halt <= 1'b0;
    wrc(ADDR_CONTROL, 32'h0000_0081, RESP_OKAY);
    periph_powerdown <= 1'b1;
    drift(d);
    chk({16'h0, d}, 32'h0000_0000);
    wrc(ADDR_CONTROL, 32'h0000_0080, RESP_OKAY);
    drift(d);
    chk(32'(d != 16'h0000), 32'h0000_0001);
    periph_powerdown <= 1'b0;
    wrc(ADDR_CONTROL, 32'h0000_0180, RESP_OKAY);
    drift(d);
    chk(32'(d inside {[16'h0003:16'h0006]}), 32'h0000_0001);
    for (i = 1; i < 3; i++) begin
      wrc(ADDR_CONTROL, 32'h0000_0180 | (i << 2), RESP_OKAY);
      drift(d);
      chk(32'(d inside {[16'h0000:16'h0001]}), 32'h0000_0001);
    end
    // secure watchdog: seed, lock, matching services, mismatch, timeout
    wrc(ADDR_CONTROL, 32'h0000_0000, RESP_OKAY);
    // with the real 32 kHz oscillator this reload of 64 ticks stands for a timeout of about 2 ms
    wrc(ADDR_RELOAD, 32'h0000_0040, RESP_OKAY);
    wrc(ADDR_SERVICE, 32'h0000_00aa, RESP_OKAY);
    wrc(ADDR_CONTROL, 32'h0000_0030, RESP_OKAY);
    wrc(ADDR_RELOAD, 32'h0000_0005, RESP_OKAY);
    rdc(ADDR_RELOAD, 32'h0000_0040, RESP_OKAY);
    wrc(ADDR_CONTROL, 32'h0000_0000, RESP_OKAY);
    rdc(ADDR_CONTROL, 32'h0000_0030, RESP_OKAY);
    for (i = 0; i < 3; i++) begin
      wait_cyc(200);
      wrc(ADDR_SERVICE, {24'h0, seq[i]}, RESP_OKAY);
      sw_u.rd(ADDR_COUNT, v, r);
      chk(32'(v >= 32'h0000_003e), 32'h0000_0001);
    end
    chk(32'(rst_seen), 32'h0000_0000);
    wrc(ADDR_SERVICE, 32'h0000_0066, RESP_OKAY);
    wait_cyc(3);
    chk(32'(rst_seen), 32'h0000_0001);
    wait_rst(2, 2000);
    chk(32'(rst_seen), 32'h0000_0002);
    // irq option in watchdog mode, after power-on reset clears the lock
    por();
    rdc(ADDR_CONTROL, 32'h0000_0000, RESP_OKAY);
    wrc(ADDR_RELOAD, 32'h0000_0008, RESP_OKAY);
    wrc(ADDR_SERVICE, 32'h0000_0001, RESP_OKAY);
    wrc(ADDR_CONTROL, 32'h0000_0022, RESP_OKAY);
    wait_irq(400);
    chk(32'(rst_seen), 32'h0000_0002);
    // zero seed forces a reset at the first service in secure watchdog mode
    por();
    wrc(ADDR_SERVICE, 32'h0000_0000, RESP_OKAY);
    wrc(ADDR_CONTROL, 32'h0000_0030, RESP_OKAY);
    wrc(ADDR_SERVICE, 32'h0000_0000, RESP_OKAY);
    wait_cyc(3);
    chk(32'(rst_seen), 32'h0000_0003);
    wrap_up();
  end
endmodule
